// ===== gbo_pkg.sv
/*
 * Shared constants for the buffer-output and poll controller.
 * Assumes a 40 MHz system clock and 32-bit classic Wishbone.
 */
package gbo_pkg;
  // ***************
  // Timing
  // ***************
  localparam int CLK_MHZ = 40;
  localparam int SETTLE_NS = 2000; // Data settle before DAV
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int POLL_NS = 2000; // Poll response window
  localparam int POLL_CYC = (POLL_NS * CLK_MHZ + 999) / 1000;
  localparam int TICK_NS = 1000; // Time-out unit
  localparam int TICK_CYC = (TICK_NS * CLK_MHZ) / 1000;
  // ***************
  // Register offsets
  // ***************
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_OPTS = 8'h04;
  localparam logic [7:0] REG_SEG = 8'h08;
  localparam logic [7:0] REG_OFF = 8'h0c;
  localparam logic [7:0] REG_ABS = 8'h10;
  localparam logic [7:0] REG_CNT = 8'h14;
  localparam logic [7:0] REG_TGT = 8'h18;
  localparam logic [7:0] REG_PPCFG = 8'h1c;
  localparam logic [7:0] REG_TMO = 8'h20;
  localparam logic [7:0] REG_PIO = 8'h24;
  localparam logic [7:0] REG_STAT = 8'h28;
  // ***************
  // Fields and reset values
  // ***************
  localparam logic [2:0] CMD_OUT = 3'h1;
  localparam logic [2:0] CMD_PASS = 3'h2;
  localparam logic [2:0] CMD_POLL = 3'h3;
  localparam logic [2:0] CMD_PPC = 3'h4;
  localparam logic [2:0] CMD_STOP = 3'h5;
  localparam int OPT_EOI = 0;
  localparam int OPT_DMA = 1;
  localparam int OPT_CONT = 2;
  localparam int OPT_AUTO = 3;
  localparam int OPT_ABS = 4;
  localparam int OPT_SYS = 5;
  localparam int OPT_CIC = 6;
  localparam int OPT_ADDR = 7;
  localparam logic [7:0] OPTS_RST = 8'h60;
  localparam int TGT_SA_LSB = 8;
  localparam int TGT_SAEN = 15;
  localparam int ST_BUSY = 0;
  localparam int ST_REL = 1;
  localparam int ST_TMO = 2;
  localparam int ST_PIOREQ = 3;
  localparam int ST_ERR = 4;
  localparam int ST_POLL_LSB = 8;
  // ***************
  // Bus messages sent under ATN
  // ***************
  localparam logic [7:0] MSG_UNL = 8'h3f;
  localparam logic [7:0] MSG_TCT = 8'h09;
  localparam logic [7:0] MSG_PPC = 8'h05;
  localparam logic [7:0] MSG_LAG = 8'h20;
  localparam logic [7:0] MSG_TAG = 8'h40;
  localparam logic [7:0] MSG_SAG = 8'h60;
  localparam logic [3:0] PPE_HI = 4'h6;
  // ***************
  // States
  // ***************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_ATN = 3'b001, ST_FETCH = 3'b010,
    ST_SEND = 3'b011, ST_POLLW = 3'b100, ST_FIN = 3'b101
  } gbo_state_e;
  typedef enum logic [1:0] {
    SH_IDLE = 2'b00, SH_RDY = 2'b01, SH_SETTLE = 2'b10, SH_ACC = 2'b11
  } gbo_sh_e;
endpackage : gbo_pkg

// ===== gbo_addr.sv
/*
 * Physical buffer address from segment:offset or absolute form.
 * Assumes inputs are register outputs on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module gbo_addr (
  input wire logic [15:0] seg_i,
  input wire logic [15:0] off_i,
  input wire logic [19:0] abs_i,
  input wire logic use_abs_i,
  output logic [19:0] phys_o
);
  import gbo_pkg::*;
  // Unsigned only, so a negative host value is its 16-bit twin
  logic [20:0] sum; // One bit spare for the carry
  // ***************
  // Conversion
  // ***************
  always_comb begin
    sum = {1'b0, seg_i, 4'h0} + {5'h00, off_i};
    // Carry past 1 MB wraps, as on a 20-bit address bus
    phys_o = use_abs_i ? abs_i : sum[19:0];
  end
endmodule : gbo_addr
`default_nettype wire

// ===== gbo_shake.sv
/*
 * Source handshake: puts one byte on DIO and runs DAV/NRFD/NDAC.
 * Assumes NRFD and NDAC are asynchronous pins, asserted = 1.
 */
`timescale 1ns/1ps
`default_nettype none
module gbo_shake (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic abort_i,
  input wire logic [7:0] byte_i,
  input wire logic last_i,
  input wire logic idy_i,
  input wire logic nrfd_i,
  input wire logic ndac_i,
  output logic [7:0] dio_o,
  output logic dio_oe_o,
  output logic eoi_o,
  output logic dav_o,
  output logic busy_o,
  output logic done_o
);
  import gbo_pkg::*;
  typedef struct packed {
    gbo_sh_e st;
    logic [1:0] nrfd_s; // [0] feeds [1] only
    logic [1:0] ndac_s;
    logic [7:0] dat;
    logic oe;
    logic last;
    logic eoi;
    logic dav;
    logic done;
    logic [7:0] cnt;
  } gbo_sh_s;
  gbo_sh_s q_r, q_nxt;
  // ***************
  // Next state
  // ***************
  always_comb begin
    q_nxt = q_r;
    q_nxt.nrfd_s = {q_r.nrfd_s[0], nrfd_i};
    q_nxt.ndac_s = {q_r.ndac_s[0], ndac_i};
    q_nxt.done = 1'b0;
    case (q_r.st)
      SH_IDLE: begin
        if (go_i) begin
          q_nxt.dat = byte_i;
          q_nxt.last = last_i;
          q_nxt.oe = 1'b1;
          q_nxt.st = SH_RDY;
        end
      end
      SH_RDY: begin
        // Wait until every listener is ready for data
        if (!q_r.nrfd_s[1]) begin
          q_nxt.cnt = 8'(SETTLE_CYC - 1);
          q_nxt.st = SH_SETTLE;
        end
      end
      SH_SETTLE: begin
        if (q_r.cnt == 8'h00) begin
          q_nxt.dav = 1'b1;
          q_nxt.st = SH_ACC;
        end else begin
          q_nxt.cnt = q_r.cnt - 8'h01;
        end
      end
      SH_ACC: begin
        // Byte taken once all listeners release NDAC
        if (!q_r.ndac_s[1]) begin
          q_nxt.dav = 1'b0;
          q_nxt.oe = 1'b0;
          q_nxt.done = 1'b1;
          q_nxt.st = SH_IDLE;
        end
      end
      default: q_nxt.st = SH_IDLE;
    endcase
    if (abort_i) begin
      q_nxt.st = SH_IDLE;
      q_nxt.dav = 1'b0;
      q_nxt.oe = 1'b0;
    end
    // EOI rides with the last byte, or with ATN during a poll
    q_nxt.eoi = idy_i | (q_nxt.oe & q_nxt.last);
  end
  // ***************
  // Registers
  // ***************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end
  assign dio_o = q_r.dat;
  assign dio_oe_o = q_r.oe;
  assign eoi_o = q_r.eoi;
  assign dav_o = q_r.dav;
  assign busy_o = (q_r.st != SH_IDLE);
  assign done_o = q_r.done;
endmodule : gbo_shake
`default_nettype wire

// ===== gbo_top.sv
/*
 * Bus controller: buffer output, pass control, parallel poll and
 * poll-reply configuration, commanded over classic Wishbone.
 * Assumes a byte memory port on clk_i and GPIB pins, asserted = 1.
 */
// The Wishbone interface to the registers and the register offsets were decided locally.
// Function
// - Physical address is segment times 16 plus offset
// - Absolute address is 20 bits wide
// - Segment and offset are unsigned 16-bit
// - EOI asserted with the last byte
// - DMA option reads bytes from memory directly
// - Non-blocking DMA releases host, finishes later
// - Release waits first byte unless time-out zero
// - Auto reload repeats until stop command
// - System controller asserts REN on output
// - Pass control hands role to addressed device
// - System controller status kept after passing
// - Parallel poll only while controller in charge
// - Poll result: bit n is DIO n+1
// - Configure byte is 0110, sense, line selector
`timescale 1ns/1ps
`default_nettype none
module gbo_top #(
  parameter logic [4:0] MY_ADDR = 5'h00 // Own talk address
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [19:0] mem_adr_o,
  output logic mem_rd_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_dat_i,
  input wire logic [7:0] dio_i,
  output logic [7:0] dio_o,
  output logic dio_oe_o,
  output logic eoi_o,
  output logic atn_o,
  output logic dav_o,
  output logic ren_o,
  input wire logic nrfd_i,
  input wire logic ndac_i
);
  import gbo_pkg::*;
  // ***************
  // State
  // ***************
  typedef struct packed {
    gbo_state_e st;
    logic [4:0][7:0] q; // Messages to send under ATN
    logic [2:0] q_n;
    logic [2:0] q_i;
    logic [2:0] post; // Command that follows the ATN bytes
    logic [7:0] opts;
    logic [15:0] seg;
    logic [15:0] off;
    logic [19:0] abs_a;
    logic [31:0] cnt;
    logic [15:0] tgt;
    logic [3:0] ppcfg;
    logic [15:0] tmo;
    logic [7:0] pio;
    logic pio_full;
    logic [19:0] cur;
    logic [31:0] rem;
    logic busy;
    logic rel;
    logic tmo_f;
    logic err;
    logic stop;
    logic [7:0] poll;
    logic [7:0] dio_s1; // Feeds dio_s2 only
    logic [7:0] dio_s2;
    logic ren;
    logic atn;
    logic idy;
    logic go;
    logic abort;
    logic [7:0] byte_v;
    logic last;
    logic mem_rd;
    logic [19:0] mem_adr;
    logic [7:0] wait_c;
    logic [5:0] tick_c;
    logic [15:0] t_cnt;
    logic ack;
    logic [31:0] rdat;
  } gbo_top_s;
  gbo_top_s r_r, r_nxt;
  logic [19:0] phys; // Buffer start address
  logic sh_busy;
  logic sh_done;
  logic acc; // Bus access this cycle
  logic wr; // Bus write this cycle
  logic tick; // One-microsecond enable
  // Byte-lane merge of a write into a register
  function automatic logic [31:0] wmask(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (nw & m);
  endfunction : wmask
  // Secondary address message from the target's secondary field
  function automatic logic [7:0] sec_msg(input logic [15:0] t);
    return MSG_SAG | {3'h0, t[TGT_SA_LSB +: 5]};
  endfunction : sec_msg
  // ***************
  // Submodules
  // ***************
  gbo_addr u_addr (
    .seg_i(r_r.seg),
    .off_i(r_r.off),
    .abs_i(r_r.abs_a),
    .use_abs_i(r_r.opts[OPT_ABS]),
    .phys_o(phys)
  );
  gbo_shake u_shake (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .go_i(r_r.go),
    .abort_i(r_r.abort),
    .byte_i(r_r.byte_v),
    .last_i(r_r.last),
    .idy_i(r_r.idy),
    .nrfd_i(nrfd_i),
    .ndac_i(ndac_i),
    .dio_o(dio_o),
    .dio_oe_o(dio_oe_o),
    .eoi_o(eoi_o),
    .dav_o(dav_o),
    .busy_o(sh_busy),
    .done_o(sh_done)
  );
  // ***************
  // Next state
  // ***************
  always_comb begin
    r_nxt = r_r;
    acc = wb_cyc_i & wb_stb_i & ~r_r.ack;
    wr = acc & wb_we_i;
    tick = (r_r.tick_c == 6'(TICK_CYC - 1));
    r_nxt.tick_c = tick ? 6'h00 : r_r.tick_c + 6'h01;
    r_nxt.dio_s1 = dio_i;
    r_nxt.dio_s2 = r_r.dio_s1;
    r_nxt.go = 1'b0;
    r_nxt.abort = 1'b0;
    r_nxt.ack = acc; // Ack one cycle after the request, then drop
    // Register writes; unmapped offsets are acked and ignored
    if (wr) begin
      case (wb_adr_i)
        REG_OPTS: r_nxt.opts = 8'(wmask({24'h0, r_r.opts}, wb_dat_i, wb_sel_i));
        REG_SEG: r_nxt.seg = 16'(wmask({16'h0, r_r.seg}, wb_dat_i, wb_sel_i));
        REG_OFF: r_nxt.off = 16'(wmask({16'h0, r_r.off}, wb_dat_i, wb_sel_i));
        REG_ABS: r_nxt.abs_a = 20'(wmask({12'h0, r_r.abs_a}, wb_dat_i, wb_sel_i));
        REG_CNT: r_nxt.cnt = wmask(r_r.cnt, wb_dat_i, wb_sel_i);
        REG_TGT: r_nxt.tgt = 16'(wmask({16'h0, r_r.tgt}, wb_dat_i, wb_sel_i));
        REG_PPCFG: r_nxt.ppcfg = 4'(wmask({28'h0, r_r.ppcfg}, wb_dat_i, wb_sel_i));
        REG_TMO: r_nxt.tmo = 16'(wmask({16'h0, r_r.tmo}, wb_dat_i, wb_sel_i));
        REG_PIO: begin
          if (wb_sel_i[0]) begin
            r_nxt.pio = wb_dat_i[7:0];
            r_nxt.pio_full = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Read mux, registered with the ack
    r_nxt.rdat = 32'h0;
    if (acc && !wb_we_i) begin
      case (wb_adr_i)
        REG_OPTS: r_nxt.rdat = {24'h0, r_r.opts};
        REG_SEG: r_nxt.rdat = {16'h0, r_r.seg};
        REG_OFF: r_nxt.rdat = {16'h0, r_r.off};
        REG_ABS: r_nxt.rdat = {12'h0, r_r.abs_a};
        REG_CNT: r_nxt.rdat = r_r.cnt;
        REG_TGT: r_nxt.rdat = {16'h0, r_r.tgt};
        REG_PPCFG: r_nxt.rdat = {28'h0, r_r.ppcfg};
        REG_TMO: r_nxt.rdat = {16'h0, r_r.tmo};
        REG_STAT: begin
          r_nxt.rdat[ST_BUSY] = r_r.busy;
          r_nxt.rdat[ST_REL] = r_r.rel;
          r_nxt.rdat[ST_TMO] = r_r.tmo_f;
          r_nxt.rdat[ST_PIOREQ] = (r_r.st == ST_FETCH) & ~r_r.opts[OPT_DMA] & ~r_r.pio_full;
          r_nxt.rdat[ST_ERR] = r_r.err;
          r_nxt.rdat[ST_POLL_LSB +: 8] = r_r.poll;
        end
        default: r_nxt.rdat = 32'h0;
      endcase
    end
    // Stop is heard at any time while busy; it ends auto-reload repetition
    if (wr && wb_adr_i == REG_CMD && wb_dat_i[2:0] == CMD_STOP && r_r.busy) begin
      r_nxt.stop = 1'b1;
    end
    case (r_r.st)
      ST_IDLE: begin
        if (wr && wb_adr_i == REG_CMD && wb_dat_i[2:0] != CMD_STOP) begin
          r_nxt.err = 1'b0;
          r_nxt.tmo_f = 1'b0;
          r_nxt.q_i = 3'h0;
          r_nxt.post = wb_dat_i[2:0];
          r_nxt.q[0] = MSG_UNL;
          r_nxt.q[1] = MSG_LAG | {3'h0, r_r.tgt[4:0]};
          r_nxt.q[2] = sec_msg(r_r.tgt);
          r_nxt.q_n = r_r.tgt[TGT_SAEN] ? 3'h3 : 3'h2;
          // Controller commands are refused unless in charge
          if (!r_r.opts[OPT_CIC] && (wb_dat_i[2:0] != CMD_OUT || r_r.opts[OPT_ADDR])) begin
            r_nxt.err = 1'b1;
          end else begin
            case (wb_dat_i[2:0])
              CMD_OUT: begin
                // Without targets the addressing is already in place
                r_nxt.q[1] = MSG_TAG | {3'h0, MY_ADDR};
                r_nxt.q[2] = MSG_LAG | {3'h0, r_r.tgt[4:0]};
                r_nxt.q[3] = sec_msg(r_r.tgt);
                r_nxt.q_n = r_r.opts[OPT_ADDR] ? (r_r.tgt[TGT_SAEN] ? 3'h4 : 3'h3) : 3'h0;
                r_nxt.cur = phys;
                r_nxt.rem = r_r.cnt;
                r_nxt.ren = r_r.ren | r_r.opts[OPT_SYS];
                r_nxt.busy = 1'b1;
                // Zero time-out releases at once, nothing to detect
                r_nxt.rel = r_r.opts[OPT_DMA] & r_r.opts[OPT_CONT] & (r_r.tmo == 16'h0);
                r_nxt.st = (r_r.cnt == 32'h0) ? ST_FIN : ST_ATN;
              end
              CMD_PASS: begin
                r_nxt.q[0] = MSG_TAG | {3'h0, r_r.tgt[4:0]};
                r_nxt.q[1] = sec_msg(r_r.tgt);
                r_nxt.q[r_r.tgt[TGT_SAEN] ? 2 : 1] = MSG_TCT;
                r_nxt.busy = 1'b1;
                r_nxt.st = ST_ATN;
              end
              CMD_POLL: begin
                r_nxt.atn = 1'b1;
                r_nxt.idy = 1'b1;
                r_nxt.wait_c = 8'(POLL_CYC - 1);
                r_nxt.busy = 1'b1;
                r_nxt.st = ST_POLLW;
              end
              CMD_PPC: begin
                r_nxt.q[r_nxt.q_n] = MSG_PPC;
                r_nxt.q[r_nxt.q_n + 3'h1] = {PPE_HI, r_r.ppcfg};
                r_nxt.q_n = r_nxt.q_n + 3'h2;
                r_nxt.busy = 1'b1;
                r_nxt.st = ST_ATN;
              end
              default: r_nxt.err = 1'b1;
            endcase
          end
        end
      end
      ST_ATN: begin
        r_nxt.atn = (r_r.q_i != r_r.q_n) | sh_busy | r_r.go;
        if (!sh_busy && !r_r.go) begin
          if (r_r.q_i == r_r.q_n) begin
            if (r_r.post == CMD_OUT) begin
              r_nxt.st = ST_FETCH;
            end else begin
              // System controller bit is untouched by passing
              if (r_r.post == CMD_PASS) begin
                r_nxt.opts[OPT_CIC] = 1'b0;
              end
              r_nxt.st = ST_FIN;
            end
          end else begin
            r_nxt.byte_v = r_r.q[r_r.q_i];
            r_nxt.last = 1'b0;
            r_nxt.go = 1'b1;
            r_nxt.q_i = r_r.q_i + 3'h1;
          end
        end
      end
      ST_FETCH: begin
        r_nxt.last = r_r.opts[OPT_EOI] & (r_r.rem == 32'h1);
        r_nxt.t_cnt = 16'h0;
        if (r_r.stop && !r_r.mem_rd) begin
          r_nxt.st = ST_FIN;
        end else if (r_r.opts[OPT_DMA]) begin
          // Memory read held until acknowledged
          r_nxt.mem_adr = r_r.cur;
          r_nxt.mem_rd = ~mem_ack_i;
          if (r_r.mem_rd && mem_ack_i) begin
            r_nxt.byte_v = mem_dat_i;
            r_nxt.go = 1'b1;
            r_nxt.st = ST_SEND;
          end
        end else if (r_r.pio_full) begin
          // Programmed transfer: software posts each byte
          r_nxt.byte_v = r_r.pio;
          r_nxt.pio_full = wr && wb_adr_i == REG_PIO && wb_sel_i[0];
          r_nxt.go = 1'b1;
          r_nxt.st = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tick && sh_busy) begin
          r_nxt.t_cnt = r_r.t_cnt + 16'h1;
        end
        if (sh_done) begin
          r_nxt.rel = r_r.rel | (r_r.opts[OPT_DMA] & r_r.opts[OPT_CONT]);
          r_nxt.cur = r_r.cur + 20'h1;
          r_nxt.rem = r_r.rem - 32'h1;
          r_nxt.st = ST_FETCH;
          if (r_r.rem == 32'h1) begin
            if (r_r.opts[OPT_AUTO] && !r_r.stop) begin
              r_nxt.cur = phys;
              r_nxt.rem = r_r.cnt;
            end else begin
              r_nxt.st = ST_FIN;
            end
          end
        end else if (r_r.tmo != 16'h0 && r_r.t_cnt >= r_r.tmo) begin
          r_nxt.tmo_f = 1'b1;
          r_nxt.abort = 1'b1;
          r_nxt.st = ST_FIN;
        end
      end
      ST_POLLW: begin
        if (r_r.wait_c == 8'h00) begin
          r_nxt.poll = r_r.dio_s2;
          r_nxt.atn = 1'b0;
          r_nxt.idy = 1'b0;
          r_nxt.st = ST_FIN;
        end else begin
          r_nxt.wait_c = r_r.wait_c - 8'h01;
        end
      end
      ST_FIN: begin
        // Non-blocking commands conclude only here
        r_nxt.busy = 1'b0;
        r_nxt.rel = 1'b1;
        r_nxt.stop = 1'b0;
        r_nxt.atn = 1'b0;
        r_nxt.mem_rd = 1'b0;
        r_nxt.st = ST_IDLE;
      end
      default: r_nxt.st = ST_IDLE;
    endcase
  end
  // ***************
  // Registers
  // ***************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_r <= '0;
      r_r.opts <= OPTS_RST;
      r_r.rel <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end
  assign wb_dat_o = r_r.rdat;
  assign wb_ack_o = r_r.ack;
  assign mem_adr_o = r_r.mem_adr;
  assign mem_rd_o = r_r.mem_rd;
  assign atn_o = r_r.atn;
  assign ren_o = r_r.ren;
endmodule : gbo_top
`default_nettype wire

// ===== gbo_chk.sv
/*
 * Port assertions for the buffer-output and poll controller.
 * Assumes one clock, synchronous reset, bound to gbo_top.
 */
`timescale 1ns/1ps
`default_nettype none
module gbo_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [19:0] mem_adr_o,
  input wire logic mem_rd_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] dio_o,
  input wire logic dio_oe_o,
  input wire logic eoi_o,
  input wire logic atn_o,
  input wire logic dav_o,
  input wire logic ren_o,
  input wire logic ndac_i
);
  // ***************
  // Sequences and properties
  // ***************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Poll phase: ATN with EOI and no data strobe
  sequence poll_hold;
    (atn_o && eoi_o && !dav_o) [*8];
  endsequence
  chk_ack_next: assert property (wb_req |=> wb_ack_o)
    else $error("request not answered next cycle");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h28 |->
    wb_dat_o == 32'h0) else $error("unmapped read not zero");
  // Data must settle on the lines before the strobe
  chk_settle_time: assert property ($rose(dav_o) |-> dio_oe_o && $past(dio_oe_o, 80))
    else $error("strobe before data settled");
  chk_byte_stable: assert property (dav_o && $past(dav_o) |->
    $stable(dio_o) && $stable(eoi_o)) else $error("byte changed under strobe");
  chk_dav_ndac: assert property ($fell(dav_o) |-> !$past(ndac_i, 2))
    else $error("strobe dropped before accept");
  chk_ren_sticky: assert property (ren_o |=> ren_o)
    else $error("remote enable dropped");
  chk_mem_hold: assert property (mem_rd_o && !mem_ack_i |=>
    mem_rd_o && $stable(mem_adr_o)) else $error("memory request not held");
  chk_poll_window: assert property ($rose(atn_o && eoi_o) |-> poll_hold)
    else $error("poll window too short");
endmodule : gbo_chk
bind gbo_top gbo_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .mem_adr_o(mem_adr_o), .mem_rd_o(mem_rd_o), .mem_ack_i(mem_ack_i),
  .dio_o(dio_o), .dio_oe_o(dio_oe_o), .eoi_o(eoi_o), .atn_o(atn_o), .dav_o(dav_o),
  .ren_o(ren_o), .ndac_i(ndac_i));
`default_nettype wire

// ===== gbo_listener.sv
/*
 * Bus instrument model: acceptor handshake and poll reply.
 * Assumes asserted = 1 on every line, same clock as the block.
 */
`timescale 1ns/1ps
`default_nettype none
module gbo_listener (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic dav_i,
  input wire logic atn_i,
  input wire logic eoi_i,
  input wire logic [7:0] dio_i,
  output logic nrfd_o,
  output logic ndac_o,
  output logic [7:0] poll_o
);
  // ***************
  // Acceptor
  // ***************
  logic [9:0] rx [0:63]; // Taken bytes as {atn, eoi, data}
  int n; // Bytes taken so far
  int wt; // Delay count for slow answers
  logic [3:0] cfg_r; // Sense and line from a configure byte
  // Takes every byte, so it stands in for prior addressing
  always @(posedge clk_i) begin
    if (rst_i) begin
      n <= 0;
      wt <= 0;
      cfg_r <= 4'h0;
      nrfd_o <= 1'b0;
      ndac_o <= 1'b1;
    end else if (dav_i && ndac_o && wt < (slow_i ? 6 : 0)) begin
      wt <= wt + 1;
    end else if (dav_i && ndac_o) begin
      rx[n[5:0]] <= {atn_i, eoi_i, dio_i};
      n <= n + 1;
      wt <= 0;
      nrfd_o <= 1'b1;
      ndac_o <= 1'b0;
      if (atn_i && dio_i[7:4] == 4'h6) cfg_r <= dio_i[3:0];
    end else if (!dav_i && !ndac_o) begin
      nrfd_o <= 1'b0;
      ndac_o <= 1'b1;
    end
  end
  // Own status is always set, so a sense of 1 means reply
  assign poll_o = (atn_i && eoi_i && cfg_r[3]) ? 8'h01 << cfg_r[2:0] : 8'h00;
endmodule : gbo_listener
`default_nettype wire

// ===== testbench.sv
/*
 * Self-checking bench for gbo_top with listener and memory model.
 * Assumes the package constants and a 40 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gbo_pkg::*;
  // ***************
  // Signals and models
  // ***************
  logic clk_i;
  logic rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, mem_dat_i = 8'h00, dio_o, poll;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, st;
  logic wb_ack_o, mem_rd_o, mem_ack_i = 1'b0, dio_oe_o, eoi_o, atn_o, dav_o, ren_o;
  logic nrfd_i, ndac_i, slow = 1'b0;
  logic [19:0] mem_adr_o;
  int num_errors = 0, tests_run = 0, base = 0, k;
  // Released data lines fall to the unasserted level
  wire logic [7:0] dio_i = (dio_oe_o ? dio_o : 8'h00) | poll;
  gbo_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_adr_o(mem_adr_o), .mem_rd_o(mem_rd_o),
    .mem_ack_i(mem_ack_i), .mem_dat_i(mem_dat_i), .dio_i(dio_i), .dio_o(dio_o),
    .dio_oe_o(dio_oe_o), .eoi_o(eoi_o), .atn_o(atn_o), .dav_o(dav_o), .ren_o(ren_o),
    .nrfd_i(nrfd_i), .ndac_i(ndac_i));
  gbo_listener lst_u (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .dav_i(dav_o),
    .atn_i(atn_o), .eoi_i(eoi_o), .dio_i(dio_i), .nrfd_o(nrfd_i), .ndac_o(ndac_i),
    .poll_o(poll));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Memory: byte is its address low byte xor 5a, one cycle late
  always @(posedge clk_i) begin
    mem_ack_i <= mem_rd_o && !mem_ack_i;
    mem_dat_i <= mem_adr_o[7:0] ^ 8'h5a;
  end
  // ***************
  // Tasks
  // ***************
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (n >= 20) chk(32'h0, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rx(input int i, input logic [9:0] e);
    chk({22'h0, lst_u.rx[base + i]}, {22'h0, e});
  endtask : rx
  // Polls status until busy clears; a hang shows as busy still set
  task automatic idle();
    st = 32'h1;
    for (k = 0; k < 3000 && st[ST_BUSY] !== 1'b0; k++) begin
      wb(1'b0, REG_STAT, 32'h0);
      st = q;
    end
    chk(32'(st[ST_BUSY]), 32'h0);
    base = lst_u.n;
  endtask : idle
  task automatic t_reset();
    wb(1'b0, REG_OPTS, 32'h0);
    chk(q & 32'hff, 32'(OPTS_RST));
    wb(1'b0, REG_STAT, 32'h0);
    chk(32'(q[ST_REL]), 32'h1);
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
  endtask : t_reset
  // Segment ffff offset 10 wraps to address 0; eoi, targets, dma
  task automatic t_out_seg();
    wb(1'b1, REG_OPTS, 32'he3);
    wb(1'b1, REG_SEG, 32'hffff);
    wb(1'b1, REG_OFF, 32'h10);
    wb(1'b1, REG_CNT, 32'h3);
    wb(1'b1, REG_TGT, 32'h5);
    wb(1'b1, REG_TMO, 32'h0);
    wb(1'b1, REG_CMD, 32'(CMD_OUT));
    idle();
    base = base - 6;
    rx(0, 10'h23f);
    rx(1, 10'h240);
    rx(2, 10'h225);
    rx(3, 10'h05a);
    rx(4, 10'h05b);
    rx(5, 10'h158);
    chk(32'(ren_o), 32'h1);
    base = lst_u.n;
  endtask : t_out_seg
  // Absolute address, secondary target, non-blocking, slow listener
  task automatic t_out_abs();
    slow <= 1'b1;
    wb(1'b1, REG_OPTS, 32'hf6);
    wb(1'b1, REG_ABS, 32'hffffe);
    wb(1'b1, REG_CNT, 32'h2);
    wb(1'b1, REG_TGT, 32'h8305);
    wb(1'b1, REG_CMD, 32'(CMD_OUT));
    wb(1'b0, REG_STAT, 32'h0);
    chk(q & 32'h3, 32'h3);
    idle();
    base = base - 6;
    rx(3, 10'h263);
    rx(4, 10'h0a4);
    rx(5, 10'h0a5);
    base = lst_u.n;
    slow <= 1'b0;
  endtask : t_out_abs
  // Auto reload repeats the two-byte buffer until stopped
  task automatic t_auto();
    int b0;
    wb(1'b1, REG_OPTS, 32'h7a);
    wb(1'b1, REG_ABS, 32'h100);
    wb(1'b1, REG_CMD, 32'(CMD_OUT));
    for (k = 0; k < 2000 && lst_u.n < base + 3; k++) @(posedge clk_i);
    wb(1'b1, REG_CMD, 32'(CMD_STOP));
    b0 = base;
    idle();
    base = b0;
    rx(2, 10'h05a);
    base = lst_u.n;
  endtask : t_auto
  task automatic t_cfg_poll();
    wb(1'b1, REG_OPTS, 32'he0);
    wb(1'b1, REG_TGT, 32'hc);
    wb(1'b1, REG_PPCFG, 32'hb);
    wb(1'b1, REG_CMD, 32'(CMD_PPC));
    idle();
    base = base - 4;
    rx(1, 10'h22c);
    rx(2, 10'h205);
    rx(3, 10'h26b);
    wb(1'b1, REG_CMD, 32'(CMD_POLL));
    idle();
    chk(32'(st[15:8]), 32'h8);
  endtask : t_cfg_poll
  // Pass control, then a poll must be refused
  task automatic t_pass();
    wb(1'b1, REG_TGT, 32'h13);
    wb(1'b1, REG_CMD, 32'(CMD_PASS));
    idle();
    base = base - 2;
    rx(0, 10'h253);
    rx(1, 10'h209);
    wb(1'b0, REG_OPTS, 32'h0);
    chk(q & 32'h60, 32'h20);
    wb(1'b1, REG_CMD, 32'(CMD_POLL));
    idle();
    chk(32'(st[ST_ERR]), 32'h1);
  endtask : t_pass
  // Programmed output, one byte
  task automatic t_pio();
    wb(1'b1, REG_OPTS, 32'h61);
    wb(1'b1, REG_CNT, 32'h1);
    wb(1'b1, REG_CMD, 32'(CMD_OUT));
    wb(1'b0, REG_STAT, 32'h0);
    chk(q & 32'h8, 32'h8);
    wb(1'b1, REG_PIO, 32'h77);
    idle();
    rx(-1, 10'h177);
  endtask : t_pio
  task automatic complete_run();
    $display("Errors: %0d, checks: %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // ***************
  // Sequence and watchdog
  // ***************
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_out_seg();
    t_out_abs();
    t_auto();
    t_cfg_poll();
    t_pass();
    t_pio();
    complete_run();
  end
  initial begin
    #1000000;
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
